// [inc/lbo_pkg.sv]
// Shared constants and types of the logic and bit operation datapath
`default_nettype none

package lbo_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int BUS_AW  = 8;
    localparam int BUS_DW  = 32;
    localparam int MEM_DEP = 16;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_WORK   = 8'h04;
    localparam logic [7:0] OFS_PORT   = 8'h08;
    localparam logic [7:0] OFS_FLAGS  = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_COUNT  = 8'h14;
    localparam logic [7:0] OFS_MEM    = 8'h40;

    // ------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_BIT_LSB = 4;
    localparam int CMD_ADR_LSB = 8;

    // Status bit positions
    localparam int STS_BAD_OP  = 0;
    localparam int STS_BAD_ADR = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [15:0] RST_CMD  = 16'h0000;
    localparam logic [15:0] RST_CNT  = 16'h0000;

    // Operation codes
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_XOR_IO_A  = 4'h1,
        OP_XOR_A_MEM = 4'h2,
        OP_XOR_MEM_A = 4'h3,
        OP_NOT_A     = 4'h4,
        OP_NOT_MEM   = 4'h5,
        OP_NEG_A     = 4'h6,
        OP_NEG_MEM   = 4'h7,
        OP_CLR_IO    = 4'h8,
        OP_SET_IO    = 4'h9,
        OP_CLR_MEM   = 4'ha,
        OP_SET_MEM   = 4'hb
    } lbo_op_type;

    // Result destinations
    typedef enum logic [1:0] {
        DST_NONE = 2'h0,
        DST_WORK = 2'h1,
        DST_PORT = 2'h2,
        DST_MEM  = 2'h3
    } lbo_dst_type;

    // Four arithmetic flags
    typedef struct packed {
        logic signed_wrap_flag;
        logic nibble_borrow_flag;
        logic borrow_flag;
        logic null_flag;
    } lbo_flags_type;

    // Datapath result
    typedef struct packed {
        lbo_dst_type dst;
        logic [7:0]  value;
        logic        upd_null;
        logic        null_val;
        logic        op_ok;
    } lbo_res_type;

    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } lbo_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lbo_apb_rsp_type;

endpackage

`default_nettype wire

// [verif/lbo_datapath_asserts.sv]
// Port-level concurrent checks of the logic and bit operation datapath
`default_nettype none

module lbo_datapath_asserts #(
    parameter int MEM_DEPTH = 16
) (
    input wire logic                     mclk_i,
    input wire logic                     srst_i,
    input wire lbo_pkg::lbo_apb_req_type apb_req_i,
    input wire lbo_pkg::lbo_apb_rsp_type apb_rsp_o,
    input wire logic [7:0]               port_a_data_o,
    input wire logic [7:0]               work_register_a_o,
    input wire lbo_pkg::lbo_flags_type   flags_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import lbo_pkg::*;

    // ------------------------------------------------------------
    // Completed writes, split by target register
    // ------------------------------------------------------------
    logic       wr_done;
    logic       wr_cmd;
    logic       wr_work;
    logic       wr_port;
    logic       wr_flags;
    logic [3:0] cmd_op;
    logic [2:0] cmd_bit;

    // Lane 0 strobe is required, so a write without it counts as none
    assign wr_done  = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready & apb_req_i.pwrite & apb_req_i.pstrb[0];
    assign wr_cmd   = wr_done & (apb_req_i.paddr == OFS_CMD);
    assign wr_work  = wr_done & (apb_req_i.paddr == OFS_WORK);
    assign wr_port  = wr_done & (apb_req_i.paddr == OFS_PORT);
    assign wr_flags = wr_done & (apb_req_i.paddr == OFS_FLAGS);
    assign cmd_op   = apb_req_i.pwdata[3:0];
    assign cmd_bit  = apb_req_i.pwdata[6:4];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------
    // Bus answer timing
    // ------------------------------------------------------------
    a_ready_pulse:
        assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("ready stood longer than one cycle");
    a_ready_wait:
        assert property (apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready |=> apb_rsp_o.pready)
        else $error("ready not given after one wait cycle");
    a_error_with_ready:
        assert property (apb_rsp_o.pslverr |-> apb_rsp_o.pready)
        else $error("error flag without ready");

    // ------------------------------------------------------------
    // Upper three flags, work and port change only for a cause
    // ------------------------------------------------------------
    a_upper_flags_kept:
        assert property (!$past(srst_i) && !$past(wr_flags) |-> $stable(flags_o[3:1]))
        else $error("borrow or wrap flags changed");
    a_port_hold:
        assert property (!$past(srst_i) && !$past(wr_port || wr_cmd) |-> $stable(port_a_data_o))
        else $error("port changed without a cause");
    a_work_hold:
        assert property (!$past(srst_i) && !$past(wr_work || wr_cmd) |-> $stable(work_register_a_o))
        else $error("work register changed without a cause");

    // ------------------------------------------------------------
    // Results of work and port operations
    // ------------------------------------------------------------
    a_not_work:
        assert property (wr_cmd && cmd_op == OP_NOT_A |=> work_register_a_o == ~$past(work_register_a_o))
        else $error("invert of work register wrong");
    a_neg_work:
        assert property (wr_cmd && cmd_op == OP_NEG_A |=> work_register_a_o == 8'h00 - $past(work_register_a_o))
        else $error("negate of work register wrong");
    a_null_zero:
        assert property (wr_cmd && (cmd_op == OP_NOT_A || cmd_op == OP_NEG_A)
            |=> flags_o.null_flag == (work_register_a_o == 8'h00))
        else $error("null flag does not match result");
    a_xor_port:
        assert property (wr_cmd && cmd_op == OP_XOR_IO_A
            |=> port_a_data_o == ($past(port_a_data_o) ^ $past(work_register_a_o)))
        else $error("exclusive-or into port wrong");
    a_port_clear:
        assert property (wr_cmd && cmd_op == OP_CLR_IO
            |=> port_a_data_o == ($past(port_a_data_o) & ~(8'h01 << $past(cmd_bit))))
        else $error("port bit clear wrong");
    a_port_set:
        assert property (wr_cmd && cmd_op == OP_SET_IO
            |=> port_a_data_o == ($past(port_a_data_o) | (8'h01 << $past(cmd_bit))))
        else $error("port bit set wrong");

    // Main scenarios reached
    c_null_set: cover property (wr_cmd && cmd_op == OP_NEG_A ##1 flags_o.null_flag);
    c_bad_adr: cover property (wr_cmd && apb_req_i.pwdata[15:8] >= MEM_DEPTH);
    c_slverr: cover property (apb_rsp_o.pslverr);
endmodule

bind lbo_datapath lbo_datapath_asserts #(.MEM_DEPTH(MEM_DEPTH)) u_asserts (
    .mclk_i            (mclk_i),
    .srst_i            (srst_i),
    .apb_req_i         (apb_req_i),
    .apb_rsp_o         (apb_rsp_o),
    .port_a_data_o     (port_a_data_o),
    .work_register_a_o (work_register_a_o),
    .flags_o           (flags_o)
);

`default_nettype wire

// [verif/lbo_datapath_tb.sv]
// Self-checking testbench of the logic and bit operation datapath
`default_nettype none

module lbo_datapath_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lbo_pkg::*;

    logic                 mclk = 1'b0;
    logic                 srst;
    lbo_apb_req_type      req;
    lbo_apb_rsp_type      rsp;
    logic [7:0]           port_a;
    logic [7:0]           work_a;
    lbo_flags_type        flags;
    logic [31:0]          rdata;
    logic                 rerr;
    int                   fail_count = 0;
    int                   num_checks = 0;

    // 10 MHz system clock
    always #50 mclk = ~mclk;

    lbo_datapath #(.MEM_DEPTH(MEM_DEP)) uut (
        .mclk_i            (mclk),
        .srst_i            (srst),
        .apb_req_i         (req),
        .apb_rsp_o         (rsp),
        .port_a_data_o     (port_a),
        .work_register_a_o (work_a),
        .flags_o           (flags)
    );

    // ------------------------------------------------------------
    // Compare, bus cycles and verdict
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; waits for ready with no assumed latency
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        int n = 0;
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: wd, pstrb: 4'hf};
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fail_count++;
            $display("Error at %0t: no ready", $time);
        end
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        xfer(1'b1, adr, wd);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic exp_err);
        xfer(1'b0, adr, 32'h0);
        check(rdata, exp);
        check({31'h0, rerr}, {31'h0, exp_err});
    endtask

    // Load operands and flags, execute one op, compare every result
    task automatic run(input lbo_op_type op, input logic [2:0] n, input logic [7:0] adr,
                       input logic [7:0] a, input logic [7:0] m, input logic [7:0] p, input logic [3:0] f,
                       input logic [7:0] ea, input logic [7:0] em, input logic [7:0] ep, input logic [3:0] ef);
        wr(OFS_WORK, {24'h0, a});
        wr(OFS_PORT, {24'h0, p});
        wr(OFS_MEM + {adr[5:0], 2'b00}, {24'h0, m});
        wr(OFS_FLAGS, {28'h0, f});
        wr(OFS_CMD, {16'h0, adr, 1'b0, n, op});
        rd(OFS_MEM + {adr[5:0], 2'b00}, {24'h0, em}, 1'b0);
        check({24'h0, work_a}, {24'h0, ea});
        check({24'h0, port_a}, {24'h0, ep});
        check({28'h0, flags}, {28'h0, ef});
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        req = '0;
        srst = 1'b1;
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        check({work_a, port_a, 12'h0, flags}, 32'h0);
        rd(OFS_MEM, 32'h0, 1'b0);
        // Operand/flag table; upper flags preset high to catch stray updates
        run(OP_XOR_IO_A, 3'h0, 8'h01, 8'h3c, 8'h00, 8'ha5, 4'hf, 8'h3c, 8'h00, 8'h99, 4'hf);
        run(OP_XOR_A_MEM, 3'h0, 8'h02, 8'h5a, 8'h5a, 8'h00, 4'he, 8'h00, 8'h5a, 8'h00, 4'hf);
        run(OP_XOR_MEM_A, 3'h0, 8'h0f, 8'h0f, 8'hf0, 8'h00, 4'hf, 8'h0f, 8'hff, 8'h00, 4'he);
        run(OP_XOR_MEM_A, 3'h0, 8'h03, 8'h66, 8'h66, 8'h00, 4'he, 8'h66, 8'h00, 8'h00, 4'hf);
        run(OP_NOT_A, 3'h0, 8'h00, 8'h38, 8'h00, 8'h00, 4'hf, 8'hc7, 8'h00, 8'h00, 4'he);
        run(OP_NOT_A, 3'h0, 8'h00, 8'hff, 8'h00, 8'h00, 4'he, 8'h00, 8'h00, 8'h00, 4'hf);
        run(OP_NOT_MEM, 3'h0, 8'h04, 8'h00, 8'h38, 8'h00, 4'hf, 8'h00, 8'hc7, 8'h00, 4'he);
        run(OP_NOT_MEM, 3'h0, 8'h0e, 8'h00, 8'hff, 8'h00, 4'he, 8'h00, 8'h00, 8'h00, 4'hf);
        run(OP_NEG_A, 3'h0, 8'h00, 8'h38, 8'h00, 8'h00, 4'hf, 8'hc8, 8'h00, 8'h00, 4'he);
        run(OP_NEG_A, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 4'he, 8'h00, 8'h00, 8'h00, 4'hf);
        run(OP_NEG_MEM, 3'h0, 8'h05, 8'h00, 8'h38, 8'h00, 4'hf, 8'h00, 8'hc8, 8'h00, 4'he);
        run(OP_NEG_MEM, 3'h0, 8'h0f, 8'h00, 8'h80, 8'h00, 4'hf, 8'h00, 8'h80, 8'h00, 4'he);
        // Every bit position, memory address stepping to the last byte
        for (int n = 0; n < 8; n++) begin
            run(OP_CLR_IO, 3'(n), 8'h00, 8'h00, 8'h00, 8'hff, 4'h5, 8'h00, 8'h00, ~(8'h01 << n), 4'h5);
            run(OP_SET_IO, 3'(n), 8'h00, 8'h00, 8'h00, 8'h00, 4'ha, 8'h00, 8'h00, 8'h01 << n, 4'ha);
            run(OP_CLR_MEM, 3'(n), 8'(2*n+1), 8'h00, 8'hff, 8'h00, 4'h5, 8'h00, ~(8'h01 << n), 8'h00, 4'h5);
            run(OP_SET_MEM, 3'(n), 8'(2*n+1), 8'h00, 8'h00, 8'h00, 4'ha, 8'h00, 8'h01 << n, 8'h00, 4'ha);
        end
        // Refused operations, unmapped address and sticky status clear
        wr(OFS_CMD, {16'h0, 8'(MEM_DEP), 8'h05});
        wr(OFS_CMD, 32'h0000_000c);
        rd(OFS_STATUS, 32'h0000_0003, 1'b0);
        rd(OFS_MEM + 8'(4 * MEM_DEP), 32'h0, 1'b1);
        wr(OFS_STATUS, 32'h0000_0003);
        rd(OFS_STATUS, 32'h0, 1'b0);
        rd(OFS_CMD, 32'h0000_000c, 1'b0);
        wr(OFS_CMD, 32'h0);
        rd(OFS_COUNT, 32'h0000_002d, 1'b0);
        give_verdict();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("Error at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule

`default_nettype wire

// [verilog/lbo_alu.sv]
// Combinational result and null-flag logic for one operation
`default_nettype none

module lbo_alu (
    input  wire lbo_pkg::lbo_op_type op_i,
    input  wire logic [7:0]          work_i,
    input  wire logic [7:0]          port_i,
    input  wire logic [7:0]          mem_i,
    input  wire logic [2:0]          bit_i,
    output lbo_pkg::lbo_res_type     res_o
);
    import lbo_pkg::*;

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    // One-hot mask of the selected bit position
    logic [7:0] bit_mask;
    assign bit_mask = 8'h01 << bit_i;

    // Value, destination and null-flag update per operation
    always_comb begin
        res_o          = '0;
        res_o.op_ok    = 1'b1;
        res_o.dst      = DST_NONE;
        case (op_i)
            OP_NONE: begin
                res_o.dst = DST_NONE;
            end
            OP_XOR_IO_A: begin
                res_o.dst   = DST_PORT;
                res_o.value = work_i ^ port_i;
            end
            OP_XOR_A_MEM: begin
                res_o.dst      = DST_WORK;
                res_o.value    = work_i ^ mem_i;
                res_o.upd_null = 1'b1;
            end
            OP_XOR_MEM_A: begin
                res_o.dst      = DST_MEM;
                res_o.value    = work_i ^ mem_i;
                res_o.upd_null = 1'b1;
            end
            OP_NOT_A: begin
                res_o.dst      = DST_WORK;
                res_o.value    = ~work_i;
                res_o.upd_null = 1'b1;
            end
            OP_NOT_MEM: begin
                res_o.dst      = DST_MEM;
                res_o.value    = ~mem_i;
                res_o.upd_null = 1'b1;
            end
            OP_NEG_A: begin
                res_o.dst      = DST_WORK;
                res_o.value    = 8'h00 - work_i;
                res_o.upd_null = 1'b1;
            end
            OP_NEG_MEM: begin
                res_o.dst      = DST_MEM;
                res_o.value    = 8'h00 - mem_i;
                res_o.upd_null = 1'b1;
            end
            OP_CLR_IO: begin
                res_o.dst   = DST_PORT;
                res_o.value = port_i & ~bit_mask;
            end
            OP_SET_IO: begin
                res_o.dst   = DST_PORT;
                res_o.value = port_i | bit_mask;
            end
            OP_CLR_MEM: begin
                res_o.dst   = DST_MEM;
                res_o.value = mem_i & ~bit_mask;
            end
            OP_SET_MEM: begin
                res_o.dst   = DST_MEM;
                res_o.value = mem_i | bit_mask;
            end
            default: begin
                res_o.op_ok = 1'b0;
            end
        endcase
        // Zero test over the full 8-bit result
        res_o.null_val = (res_o.value == 8'h00);
    end

endmodule

`default_nettype wire

// [verilog/lbo_datapath.sv]
// Logic and bit operation datapath with APB register access

`default_nettype none

module lbo_datapath #(
    parameter int MEM_DEPTH = lbo_pkg::MEM_DEP
) (
    input  wire logic                     mclk_i,
    input  wire logic                     srst_i,
    input  wire lbo_pkg::lbo_apb_req_type apb_req_i,
    output lbo_pkg::lbo_apb_rsp_type      apb_rsp_o,
    output logic [7:0]                    port_a_data_o,
    output logic [7:0]                    work_register_a_o,
    output lbo_pkg::lbo_flags_type        flags_o
);
    import lbo_pkg::*;

    // Depth is a power of two
    localparam int MAW = $clog2(MEM_DEPTH);

    // ------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------
    // True when the byte address falls in the memory window and is word aligned
    function automatic logic is_mem_adr(input logic [7:0] adr);
        logic [7:0] top;

        // Window end
        top = 8'(OFS_MEM + 8'(MEM_DEPTH * 4));
        is_mem_adr = (adr >= OFS_MEM) && (adr < top)
                     && (adr[1:0] == 2'b00);
    endfunction

    // Memory index behind a window address
    function automatic logic [MAW-1:0] mem_idx(input logic [7:0] adr);
        logic [7:0] ofs;

        // Word index
        ofs = 8'(adr - OFS_MEM);
        mem_idx = ofs[MAW+1:2];
    endfunction

    // True for any mapped register address
    function automatic logic is_mapped(input logic [7:0] adr);
        is_mapped = (adr == OFS_CMD)
                    || (adr == OFS_WORK)
                    || (adr == OFS_PORT)
                    || (adr == OFS_FLAGS)
                    || (adr == OFS_STATUS)
                    || (adr == OFS_COUNT)
                    || is_mem_adr(adr);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Software-visible state
    logic [7:0]    work_a_reg;
    logic [7:0]    port_a_reg;
    lbo_flags_type flags_reg;
    logic [7:0]    mem_reg [MEM_DEPTH];

    // Command, errors, count
    logic [15:0]   cmd_reg;
    logic [1:0]    status_reg;
    logic [15:0]   exec_cnt_reg;

    // Bus answer
    logic          ack_reg;
    logic [31:0]   rdata_reg;
    logic          err_reg;

    // ------------------------------------------------------------
    // APB phase decode
    // ------------------------------------------------------------
    // One wait state: first access cycle prepares the answer
    logic access;
    logic done;
    logic wr_done;

    // Request fields
    logic [7:0] adr;
    logic [31:0] wdat;
    logic [3:0] strb;

    assign adr     = apb_req_i.paddr;
    assign wdat    = apb_req_i.pwdata;
    assign strb    = apb_req_i.pstrb;
    assign access  = apb_req_i.psel && apb_req_i.penable;
    assign done    = access && ack_reg;
    assign wr_done = done && apb_req_i.pwrite
                     && is_mapped(adr);

    // Per-register write strobes, lane 0 carries byte data
    logic wr_cmd;
    logic wr_work;
    logic wr_port;
    logic wr_flags;
    logic wr_status;
    logic wr_mem;

    // Refused writes: no strobe
    assign wr_cmd    = wr_done && (adr == OFS_CMD) && strb[0];
    assign wr_work   = wr_done && (adr == OFS_WORK) && strb[0];
    assign wr_port   = wr_done && (adr == OFS_PORT) && strb[0];
    assign wr_flags  = wr_done && (adr == OFS_FLAGS) && strb[0];
    assign wr_status = wr_done && (adr == OFS_STATUS) && strb[0];
    assign wr_mem    = wr_done && is_mem_adr(adr) && strb[0];

    // ------------------------------------------------------------
    // Command fields
    // ------------------------------------------------------------
    // Address lane ignored when its strobe is low
    logic [7:0]     cmd_adr;
    logic [2:0]     cmd_bit;
    logic [3:0]     cmd_op_raw;
    lbo_op_type     cmd_op;
    logic           adr_ok;
    logic [MAW-1:0] cmd_idx;

    // Fields from the lanes
    assign cmd_op_raw = wdat[CMD_OP_LSB +: 4];
    assign cmd_op     = lbo_op_type'(cmd_op_raw);
    assign cmd_bit    = wdat[CMD_BIT_LSB +: 3];
    assign cmd_adr    = strb[1] ? wdat[CMD_ADR_LSB +: 8]
                                : RST_BYTE;
    // Full width, no aliasing
    assign adr_ok     = (32'(cmd_adr) < 32'(MEM_DEPTH));
    assign cmd_idx    = cmd_adr[MAW-1:0];

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    // Result of the bus command
    lbo_res_type res;
    logic [7:0]  mem_rd;

    // Out-of-range addresses read as zero, never index the array
    assign mem_rd = adr_ok ? mem_reg[cmd_idx] : RST_BYTE;

    // Operand select and result
    lbo_alu u_alu (
        .op_i   (cmd_op),
        .work_i (work_a_reg),
        .port_i (port_a_reg),
        .mem_i  (mem_rd),
        .bit_i  (cmd_bit),
        .res_o  (res)
    );

    // A memory op with a bad address is refused whole
    logic needs_mem;
    logic exec;
    logic bad_op;
    logic bad_adr;

    // Op 2 reads memory too
    assign needs_mem = (res.dst == DST_MEM)
                       || (cmd_op == OP_XOR_A_MEM);
    assign bad_op    = wr_cmd && !res.op_ok;
    assign bad_adr   = wr_cmd && res.op_ok && needs_mem
                       && !adr_ok;
    assign exec      = wr_cmd && res.op_ok
                       && !(needs_mem && !adr_ok);

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // Ready one cycle after the access phase opens
    // Pulse, so back to back is safe
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access && !ack_reg;
        end
    end

    // Read data and error are captured with the answer
    // Unmapped: zero and error
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end else if (access && !ack_reg) begin
            err_reg   <= !is_mapped(adr);
            rdata_reg <= 32'h0000_0000;
            // Writes answer zero
            if (!apb_req_i.pwrite) begin
                case (1'b1)
                    (adr == OFS_CMD):    rdata_reg <= {16'h0000, cmd_reg};
                    (adr == OFS_WORK):   rdata_reg <= {24'h000000, work_a_reg};
                    (adr == OFS_PORT):   rdata_reg <= {24'h000000, port_a_reg};
                    (adr == OFS_FLAGS):  rdata_reg <= {28'h0000000, flags_reg};
                    (adr == OFS_STATUS): rdata_reg <= {30'h00000000, status_reg};
                    (adr == OFS_COUNT):  rdata_reg <= {16'h0000, exec_cnt_reg};
                    is_mem_adr(adr):     rdata_reg <= {24'h000000, mem_reg[mem_idx(adr)]};
                    default:             rdata_reg <= 32'h0000_0000;
                endcase
            end
        end else if (!access) begin
            err_reg <= 1'b0;
        end
    end

    // Error only with ready
    assign apb_rsp_o.prdata  = rdata_reg;
    assign apb_rsp_o.pready  = ack_reg;
    assign apb_rsp_o.pslverr = err_reg && ack_reg;

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    // Keeps the last command word for software to read back
    // Address lane needs its strobe
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cmd_reg <= RST_CMD;
        end else if (wr_cmd) begin
            cmd_reg <= {cmd_adr, 1'b0, cmd_bit, cmd_op_raw};
        end
    end

    // ------------------------------------------------------------
    // Work register
    // ------------------------------------------------------------
    // An op wins over a load
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            work_a_reg <= RST_BYTE;
        end else if (exec && res.dst == DST_WORK) begin
            work_a_reg <= res.value;
        end else if (wr_work) begin
            work_a_reg <= wdat[7:0];
        end
    end

    // ------------------------------------------------------------
    // Port A data register
    // ------------------------------------------------------------
    // Bit ops rewrite the whole byte with only bit n changed
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            port_a_reg <= RST_BYTE;
        end else if (exec && res.dst == DST_PORT) begin
            port_a_reg <= res.value;
        end else if (wr_port) begin
            port_a_reg <= wdat[7:0];
        end
    end

    // ------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------
    // Read-modify-write completes in the command's own cycle
    // Refused ops leave it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_reg[i] <= RST_BYTE;
            end
        end else if (exec && res.dst == DST_MEM) begin
            mem_reg[cmd_idx] <= res.value;
        end else if (wr_mem) begin
            mem_reg[mem_idx(adr)] <= wdat[7:0];
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    // Borrow, nibble-borrow and wrap are never touched by these ops
    // Software may preset all
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            flags_reg <= lbo_flags_type'(RST_FLAGS);
        end else if (exec && res.upd_null) begin
            flags_reg.null_flag <= res.null_val;
        end else if (wr_flags) begin
            flags_reg <= lbo_flags_type'(wdat[3:0]);
        end
    end

    // ------------------------------------------------------------
    // Status and counter
    // ------------------------------------------------------------
    // Sticky error bits; a new event wins over a write-one clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            status_reg <= 2'b00;
        end else begin
            // Write one to clear
            if (wr_status && wdat[STS_BAD_OP]) begin
                status_reg[STS_BAD_OP] <= 1'b0;
            end
            if (wr_status && wdat[STS_BAD_ADR]) begin
                status_reg[STS_BAD_ADR] <= 1'b0;
            end

            // Events last, so set wins
            if (bad_op) begin
                status_reg[STS_BAD_OP] <= 1'b1;
            end
            if (bad_adr) begin
                status_reg[STS_BAD_ADR] <= 1'b1;
            end
        end
    end

    // Executed commands, wraps at full scale
    // Refused ops not counted
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            exec_cnt_reg <= RST_CNT;
        end else if (exec) begin
            exec_cnt_reg <= 16'(exec_cnt_reg + 16'h0001);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All from flip-flops
    assign port_a_data_o     = port_a_reg;
    assign work_register_a_o = work_a_reg;
    assign flags_o           = flags_reg;

endmodule

`default_nettype wire
